// *** include/tcs_map.vh ***
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

// register offsets, word index on the plain port
`define TCS_ADDR_W 4
`define TCS_OFF_CTL0 4'h0
`define TCS_OFF_CTL5 4'h5
`define TCS_OFF_SYNC 4'h6
`define TCS_OFF_MODE 4'h7
`define TCS_OFF_STAT 4'h8

// per-channel control field positions
`define TCS_CCLR_HI 7
`define TCS_CCLR_LO 5
`define TCS_CKEG_HI 4
`define TCS_CKEG_LO 3
`define TCS_TPSC_HI 2
`define TCS_TPSC_LO 0

// mode register bits
`define TCS_MODE_BUFC0 0
`define TCS_MODE_BUFD0 1
`define TCS_MODE_BUFC3 2
`define TCS_MODE_BUFD3 3
`define TCS_MODE_PH1 4
`define TCS_MODE_PH2 5

// reset values
`define TCS_CTL_RST 8'h00
`define TCS_SYNC_RST 6'h00
`define TCS_MODE_RST 6'h00

// prescaler width and taps: bit k toggles at clock / 2^(k+1)
`define TCS_PRE_W 10
`define TCS_TAP_DIV4 1
`define TCS_TAP_DIV16 3
`define TCS_TAP_DIV64 5
`define TCS_TAP_DIV256 7
`define TCS_TAP_DIV1024 9

`endif

// *** design/tcs_pin_edge.v ***
`timescale 1ns/100ps
`default_nettype none

module tcs_pin_edge (
  input wire ref_clk,
  input wire rst,
  input wire pin,
  output reg level,
  output reg rise,
  output reg fall
);

  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // first flop feeds only the second
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      level <= sync_reg;
      rise <= sync_reg & ~prev_reg;
      fall <= ~sync_reg & prev_reg;
    end
  end

endmodule // tcs_pin_edge

`default_nettype wire

// *** design/tcs_clear_clock_sel.v ***
// Operation
// - ch0/3 clear: 000,100 off; 001 on reg A event; 010 on reg B.
// - ch0/3 clear: 101 on reg C event; 110 on reg D event.
// - clear codes x11 follow clearing of another synchronous channel.
// - synchronous clearing only while the channel's sync bit is 1.
// - reg C/D as buffer: no event, and never clears the counter.
// - ch1/2/4/5 clear select top bit reads 0, writes ignored.
// - ch1/2/4/5 clear: 00 off, 01 reg A, 10 reg B, 11 sync.
// - ch0-2 clock codes 000-011: system clock /1, /4, /16, /64.
// - ch0 clock codes 100-111: external inputs A, B, C, D.
// - ch1: 100 ext A, 101 ext B, 110 /256, 111 ch2 over/underflow.
// - ch2: 100-110 ext A, B, C; 111 system clock /1024.
// - ch1/ch2 in phase counting ignore their clock select.
// - edge field: 00 rising, 01 falling, 1x both edges.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "tcs_map.vh"

module tcs_clear_clock_sel (
  input wire ref_clk,
  input wire rst,
  input wire [`TCS_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [5:0] match_a,
  input wire [5:0] match_b,
  input wire [1:0] match_c,
  input wire [1:0] match_d,
  input wire ext_clock_in_a,
  input wire ext_clock_in_b,
  input wire ext_clock_in_c,
  input wire ext_clock_in_d,
  input wire channel2_ovf,
  input wire [1:0] phase_count_en,
  output reg [5:0] counter_clear,
  output reg [2:0] count_en
);

  reg [7:0] ctl_reg [0:5];
  reg [5:0] sync_reg;
  reg [5:0] mode_reg;
  reg [`TCS_PRE_W-1:0] pre_reg;
  reg [4:0] tap_prev_reg;
  reg [5:0] clear_next;
  reg [2:0] count_next;
  reg [5:0] own_clr;
  reg [5:0] sync_take;
  reg [7:0] rdata_next;
  reg [2:0] sel;
  reg sync_src;
  wire [4:0] taps;
  wire [4:0] tap_rise;
  wire [4:0] tap_fall;
  wire [3:0] ext_level;
  wire [3:0] ext_rise;
  wire [3:0] ext_fall;
  wire [5:0] c_ev;
  wire [5:0] d_ev;
  integer i;

  // pick the counting edge from rise/fall pulses
  function edge_pick;
    input r;
    input f;
    input [1:0] eg;
    begin
      if (eg[1])
        edge_pick = r | f;
      else if (eg[0])
        edge_pick = f;
      else
        edge_pick = r;
    end
  endfunction

  // own clear source; codes x11 handled by sync logic
  function clr_src;
    input [2:0] s;
    input a;
    input b;
    input c;
    input d;
    begin
      case (s)
        3'h1: clr_src = a;
        3'h2: clr_src = b;
        3'h5: clr_src = c;
        3'h6: clr_src = d;
        default: clr_src = 1'b0;
      endcase
    end
  endfunction

  // writable top clear-select bit exists only on channels 0 and 3
  function has_cd;
    input integer ch;
    begin
      has_cd = (ch == 0) || (ch == 3);
    end
  endfunction

  tcs_pin_edge u_pin_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_clock_in_a),
    .level(ext_level[0]),
    .rise(ext_rise[0]),
    .fall(ext_fall[0])
  );

  tcs_pin_edge u_pin_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_clock_in_b),
    .level(ext_level[1]),
    .rise(ext_rise[1]),
    .fall(ext_fall[1])
  );

  tcs_pin_edge u_pin_c (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_clock_in_c),
    .level(ext_level[2]),
    .rise(ext_rise[2]),
    .fall(ext_fall[2])
  );

  tcs_pin_edge u_pin_d (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_clock_in_d),
    .level(ext_level[3]),
    .rise(ext_rise[3]),
    .fall(ext_fall[3])
  );

  // buffer mode masks the reg C/D events
  assign c_ev = {2'b00,
                 match_c[1] & ~mode_reg[`TCS_MODE_BUFC3],
                 2'b00,
                 match_c[0] & ~mode_reg[`TCS_MODE_BUFC0]};
  assign d_ev = {2'b00,
                 match_d[1] & ~mode_reg[`TCS_MODE_BUFD3],
                 2'b00,
                 match_d[0] & ~mode_reg[`TCS_MODE_BUFD0]};

  assign taps = {pre_reg[`TCS_TAP_DIV1024], pre_reg[`TCS_TAP_DIV256],
                 pre_reg[`TCS_TAP_DIV64], pre_reg[`TCS_TAP_DIV16],
                 pre_reg[`TCS_TAP_DIV4]};
  assign tap_rise = taps & ~tap_prev_reg;
  assign tap_fall = ~taps & tap_prev_reg;

  // clearing sources, one cycle to the output flop
  always @* begin
    own_clr = 6'h00;
    sync_take = 6'h00;
    sel = 3'h0;
    for (i = 0; i < 6; i = i + 1) begin
      sel = ctl_reg[i][`TCS_CCLR_HI:`TCS_CCLR_LO];
      own_clr[i] = clr_src(sel, match_a[i], match_b[i], c_ev[i], d_ev[i]);
      sync_take[i] = sync_reg[i] & (sel[1:0] == 2'h3);
    end
    // only own clears propagate, so no combinational loop
    sync_src = |(own_clr & sync_reg);
    clear_next = own_clr | (sync_take & {6{sync_src}});
  end

  // count enable selection for channels 0 to 2
  always @* begin
    count_next = 3'h0;
    case (ctl_reg[0][`TCS_TPSC_HI:`TCS_TPSC_LO])
      3'h0: count_next[0] = 1'b1;
      3'h1: count_next[0] = edge_pick(tap_rise[0], tap_fall[0],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h2: count_next[0] = edge_pick(tap_rise[1], tap_fall[1],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h3: count_next[0] = edge_pick(tap_rise[2], tap_fall[2],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h4: count_next[0] = edge_pick(ext_rise[0], ext_fall[0],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h5: count_next[0] = edge_pick(ext_rise[1], ext_fall[1],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h6: count_next[0] = edge_pick(ext_rise[2], ext_fall[2],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h7: count_next[0] = edge_pick(ext_rise[3], ext_fall[3],
                                      ctl_reg[0][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      default: count_next[0] = 1'b0;
    endcase
    case (ctl_reg[1][`TCS_TPSC_HI:`TCS_TPSC_LO])
      3'h0: count_next[1] = 1'b1;
      3'h1: count_next[1] = edge_pick(tap_rise[0], tap_fall[0],
                                      ctl_reg[1][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h2: count_next[1] = edge_pick(tap_rise[1], tap_fall[1],
                                      ctl_reg[1][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h3: count_next[1] = edge_pick(tap_rise[2], tap_fall[2],
                                      ctl_reg[1][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h4: count_next[1] = edge_pick(ext_rise[0], ext_fall[0],
                                      ctl_reg[1][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h5: count_next[1] = edge_pick(ext_rise[1], ext_fall[1],
                                      ctl_reg[1][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h6: count_next[1] = edge_pick(tap_rise[3], tap_fall[3],
                                      ctl_reg[1][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h7: count_next[1] = channel2_ovf; // edge field ignored
      default: count_next[1] = 1'b0;
    endcase
    case (ctl_reg[2][`TCS_TPSC_HI:`TCS_TPSC_LO])
      3'h0: count_next[2] = 1'b1;
      3'h1: count_next[2] = edge_pick(tap_rise[0], tap_fall[0],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h2: count_next[2] = edge_pick(tap_rise[1], tap_fall[1],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h3: count_next[2] = edge_pick(tap_rise[2], tap_fall[2],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h4: count_next[2] = edge_pick(ext_rise[0], ext_fall[0],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h5: count_next[2] = edge_pick(ext_rise[1], ext_fall[1],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h6: count_next[2] = edge_pick(ext_rise[2], ext_fall[2],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      3'h7: count_next[2] = edge_pick(tap_rise[4], tap_fall[4],
                                      ctl_reg[2][`TCS_CKEG_HI:`TCS_CKEG_LO]);
      default: count_next[2] = 1'b0;
    endcase
    if (mode_reg[`TCS_MODE_PH1])
      count_next[1] = phase_count_en[0];
    if (mode_reg[`TCS_MODE_PH2])
      count_next[2] = phase_count_en[1];
  end

  // read mux; unmapped offsets read zero
  always @* begin
    rdata_next = 8'h00;
    if (addr <= `TCS_OFF_CTL5)
      rdata_next = ctl_reg[addr[2:0]];
    else if (addr == `TCS_OFF_SYNC)
      rdata_next = {2'b00, sync_reg};
    else if (addr == `TCS_OFF_MODE)
      rdata_next = {2'b00, mode_reg};
    else if (addr == `TCS_OFF_STAT)
      rdata_next = {1'b0, count_en, ext_level};
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 6; i = i + 1)
        ctl_reg[i] <= `TCS_CTL_RST;
      sync_reg <= `TCS_SYNC_RST;
      mode_reg <= `TCS_MODE_RST;
      rdata <= 8'h00;
    end else begin
      if (wr) begin
        for (i = 0; i < 6; i = i + 1) begin
          if (addr == i[`TCS_ADDR_W-1:0]) begin
            ctl_reg[i] <= wdata;
            if (!has_cd(i))
              ctl_reg[i][`TCS_CCLR_HI] <= 1'b0;
          end
        end
        if (addr == `TCS_OFF_SYNC)
          sync_reg <= wdata[5:0];
        if (addr == `TCS_OFF_MODE)
          mode_reg <= wdata[5:0];
      end
      // data stands only in the cycle after the strobe
      if (rd)
        rdata <= rdata_next;
      else
        rdata <= 8'h00;
    end
  end

  // free-running prescaler shared by channels 0 to 2
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_reg <= {`TCS_PRE_W{1'b0}};
      tap_prev_reg <= 5'h00;
      counter_clear <= 6'h00;
      count_en <= 3'h0;
    end else begin
      pre_reg <= pre_reg + {{(`TCS_PRE_W-1){1'b0}}, 1'b1};
      tap_prev_reg <= taps;
      counter_clear <= clear_next;
      count_en <= count_next;
    end
  end

endmodule // tcs_clear_clock_sel

`default_nettype wire

// *** verif/tcs_clear_clock_sel_chk.sv ***
`timescale 1ns/100ps
`default_nettype none

module tcs_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [5:0] match_a,
  input wire logic channel2_ovf,
  input wire logic [1:0] phase_count_en,
  input wire logic [5:0] counter_clear,
  input wire logic [2:0] count_en
);
  // shadows of written registers, since only the ports are visible here
  logic [7:0] c0_reg, c1_reg, sy_reg, md_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      sy_reg <= 8'h00;
      md_reg <= 8'h00;
    end else if (wr) begin
      if (addr == 4'h0) c0_reg <= wdata;
      if (addr == 4'h1) c1_reg <= wdata;
      if (addr == 4'h6) sy_reg <= wdata;
      if (addr == 4'h7) md_reg <= wdata;
    end
  end
  a_rsvd_top: assert property (
    rd && addr inside {4'h1, 4'h2, 4'h4, 4'h5} |=> !rdata[7])
    else $error("reserved clear bit read as 1");
  a_clr_rega: assert property (
    match_a[0] && c0_reg[7:5] == 3'b001 |=> counter_clear[0])
    else $error("reg A match did not clear channel 0");
  a_buf_noclr: assert property (
    c0_reg[7:5] == 3'b101 && md_reg[0] |=> !counter_clear[0])
    else $error("buffered reg C cleared channel 0");
  a_sync_follow: assert property (
    match_a[0] && c0_reg[7:5] == 3'b001 && sy_reg[1:0] == 2'b11
    && c1_reg[6:5] == 2'b11 |=> counter_clear[1])
    else $error("channel 1 missed synchronous clear");
  a_sync_gate: assert property (
    c1_reg[6:5] == 2'b11 && !sy_reg[1] |=> !counter_clear[1])
    else $error("channel 1 cleared without sync bit");
  a_ovf_cnt: assert property (
    c1_reg[2:0] == 3'h7 && !md_reg[4] && channel2_ovf |=> count_en[1])
    else $error("channel 2 overflow not counted");
  a_phase_src: assert property (
    md_reg[4] |=> count_en[1] == $past(phase_count_en[0]))
    else $error("phase mode count differs from phase pulse");
  a_div_one: assert property (
    !$past(rst) && c0_reg[2:0] == 3'h0 |=> count_en[0])
    else $error("divide by one not counting every cycle");
  c_sync_hit: cover property (counter_clear[1] && sy_reg[1]);
  c_phase_cnt: cover property (md_reg[4] && count_en[1]);
  c_unmapped_rd: cover property (rd && addr == 4'h9);
endmodule // tcs_chk

bind tcs_clear_clock_sel tcs_chk tcs_chk_i (.ref_clk(ref_clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .match_a(match_a), .channel2_ovf(channel2_ovf),
  .phase_count_en(phase_count_en), .counter_clear(counter_clear),
  .count_en(count_en));

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ovf = 1'b0;
  logic [3:0] addr = 4'h0, pins = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [5:0] ma = 6'h00, mb = 6'h00, cc;
  logic [1:0] mc = 2'h0, mtd = 2'h0, ph = 2'h0;
  logic [2:0] ce;
  int errors = 0, n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  tcs_clear_clock_sel tcs_clear_clock_sel_i (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .match_a(ma), .match_b(mb), .match_c(mc), .match_d(mtd),
    .ext_clock_in_a(pins[0]), .ext_clock_in_b(pins[1]),
    .ext_clock_in_c(pins[2]), .ext_clock_in_d(pins[3]),
    .channel2_ovf(ovf), .phase_count_en(ph), .counter_clear(cc),
    .count_en(ce));
  task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(logic [3:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 check("rdata", exp, rdata);
  endtask
  task automatic fire(int ch, int s, logic [5:0] exp);
    @(posedge ref_clk);
    ma <= (s == 0) ? 6'h01 << ch : 6'h00;
    mb <= (s == 1) ? 6'h01 << ch : 6'h00;
    mc <= {ch == 3 && s == 2, ch == 0 && s == 2};
    mtd <= {ch == 3 && s == 3, ch == 0 && s == 3};
    @(posedge ref_clk);
    ma <= 6'h00;
    mb <= 6'h00;
    mc <= 2'h0;
    mtd <= 2'h0;
    // clear pulse stands only in the cycle after the match edge
    #1 check("counter_clear", {2'h0, exp}, {2'h0, cc});
  endtask
  task automatic clr_case(int ch, int c, logic [7:0] mode, int s, bit e);
    wreg(4'(ch), {3'(c), 5'h00});
    wreg(4'h7, mode);
    fire(ch, s, e ? 6'h01 << ch : 6'h00);
  endtask
  // stimulus stops at cycle 32 so the pin pipeline drains inside the window
  task automatic clk_case(int ch, logic [7:0] ctl, logic [7:0] mode, int n,
    int k, int exp);
    int cnt = 0;
    wreg(4'(ch), ctl);
    wreg(4'h7, mode);
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (i < 32 && i % 8 == 0) begin
        if (k > 0 && k < 5) pins[k-1] <= ~pins[k-1];
        ovf <= (k == 5);
        ph <= (k == 6) ? 2'(ch) : 2'h0;
      end else begin
        ovf <= 1'b0;
        ph <= 2'h0;
      end
      #1 if (ce[ch] === 1'b1) cnt++;
    end
    check("count_en pulses", 8'(exp), 8'(cnt));
  endtask
  task automatic s_regs();
    rchk(4'h0, 8'h00);
    rchk(4'h6, 8'h00);
    for (int a = 0; a < 6; a++) begin
      wreg(4'(a), 8'hff);
      rchk(4'(a), (a == 0 || a == 3) ? 8'hff : 8'h7f);
    end
    wreg(4'h9, 8'hff);
    rchk(4'h9, 8'h00);
  endtask
  task automatic s_clear();
    for (int c = 0; c < 8; c++)
      for (int s = 0; s < 4; s++)
        clr_case(0, c, 8'h00, s, (c == 1 && s == 0) || (c == 2 && s == 1)
          || (c == 5 && s == 2) || (c == 6 && s == 3));
    for (int c = 0; c < 4; c++)
      for (int s = 0; s < 2; s++)
        clr_case(1, c, 8'h00, s, (c == 1 && s == 0) || (c == 2 && s == 1));
    clr_case(3, 1, 8'h00, 0, 1'b1);
    clr_case(3, 5, 8'h00, 2, 1'b1);
    clr_case(3, 6, 8'h00, 3, 1'b1);
    clr_case(3, 5, 8'h04, 2, 1'b0);
    clr_case(3, 6, 8'h08, 3, 1'b0);
    clr_case(0, 5, 8'h01, 2, 1'b0);
    clr_case(0, 6, 8'h02, 3, 1'b0);
  endtask
  task automatic s_sync();
    wreg(4'h0, 8'h20);
    wreg(4'h1, 8'h60);
    wreg(4'h6, 8'h03);
    fire(0, 0, 6'h03);
    wreg(4'h6, 8'h01);
    fire(0, 0, 6'h01);
    wreg(4'h2, 8'h00);
    rchk(4'h8, 8'h70);
  endtask
  task automatic s_clock();
    clk_case(0, 8'h00, 8'h00, 16, 0, 16);
    clk_case(0, 8'h01, 8'h00, 256, 0, 64);
    clk_case(0, 8'h02, 8'h00, 256, 0, 16);
    clk_case(0, 8'h03, 8'h00, 256, 0, 4);
    clk_case(0, 8'h09, 8'h00, 256, 0, 64);
    clk_case(0, 8'h11, 8'h00, 256, 0, 128);
    clk_case(1, 8'h06, 8'h00, 512, 0, 2);
    clk_case(2, 8'h07, 8'h00, 1024, 0, 1);
    clk_case(1, 8'h07, 8'h00, 48, 5, 4);
    for (int k = 1; k < 5; k++)
      clk_case(0, 8'(k + 3), 8'h00, 48, k, 2);
    clk_case(0, 8'h14, 8'h00, 48, 1, 4);
    clk_case(0, 8'h0c, 8'h00, 48, 1, 2);
    for (int k = 1; k < 3; k++)
      clk_case(1, 8'(k + 3), 8'h00, 48, k, 2);
    for (int k = 1; k < 4; k++)
      clk_case(2, 8'(k + 3), 8'h00, 48, k, 2);
    clk_case(1, 8'h00, 8'h10, 48, 6, 4);
    clk_case(2, 8'h00, 8'h20, 48, 6, 4);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    s_regs();
    s_clear();
    s_sync();
    s_clock();
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
